// ===== fsv_consts.vh
`ifndef FSV_CONSTS_VH
`define FSV_CONSTS_VH
// Fault display codes
`define FSV_CODE_NONE 8'h00
`define FSV_CODE_EXTERNAL 8'h12
`define FSV_CODE_GUARD 8'h13
`define FSV_CODE_MAINS 8'h15
`define FSV_CODE_TEMP 8'h21
`define FSV_CODE_GATE 8'h30
`define FSV_CODE_THERM 8'h35
`define FSV_CODE_COMM 8'h60
`define FSV_CODE_UNDERV 16'h8888
// Function selector values
`define FSV_FN_ALARM_OUT 8'h05
`define FSV_FN_ACK_IN 8'h18
`define FSV_FN_RELAY_ALARM 8'h00
`define FSV_CLR_A 8'h00
`define FSV_CLR_B 8'h02
`define FSV_RST_RISE_STOP 8'h00
`define FSV_RST_FALL_STOP 8'h01
`define FSV_RST_RISE_ONLY 8'h02
// Register byte addresses
`define FSV_A_CTRL 12'h000
`define FSV_A_RESET_EDGE 12'h004
`define FSV_A_OUT1_FN 12'h008
`define FSV_A_OUT2_FN 12'h00c
`define FSV_A_RELAY_FN 12'h010
`define FSV_A_IN_FN_BASE 12'h014
`define FSV_A_HIST_CLEAR 12'h028
`define FSV_A_STATUS 12'h02c
`define FSV_A_COUNT 12'h030
`define FSV_A_REC_BASE 12'h040
`define FSV_REC_STRIDE 12'h020
// Reset values
`define FSV_RST_IN_FN 8'h00
`define FSV_HIST_CLR_IDLE 8'hff
// Timing
`define FSV_ALARM_DELAY_MS 300
`define FSV_MAINS_DELAY_S 40'd100
`define FSV_CLK_HZ 50000000
`endif

// ===== fsv_fault_supervisor.v
`timescale 1ns/1ps
`default_nettype none
`include "fsv_consts.vh"
// How it works
// RULE1: external-fault input raises code 12
// RULE2: guard active at power-up or dip: code 13; code raises it on a dip edge only, as clean is still zero while powerup is set
// RULE3: mains overvoltage raises 15 after 100 s; code never clears mains_cnt, so time adds up and later trips come at once
// RULE4: power section overtemperature raises code 21
// RULE5: gate array error: 30, inhibit at once
// RULE6: thermistor input raises code 35
// RULE7: serial timeout raises code 60
// RULE8: undervoltage shows 8888, output off immediately
// RULE9: three records readable newest first
// RULE10: new record enters newest, others shift
// RULE11: record holds count, code and snapshots
// RULE12: history clear on value 00 or 02
// RULE13: alarm-assigned outputs follow fault present
// RULE14: relay carries alarm by default, value 00
// RULE15: relay energised when healthy, drops on fault
// RULE16: output selector 05 assigns alarm
// RULE17: alarm output about 300 ms after fault
// RULE18: input selector 18 acknowledges; input 5 default
// RULE19: host pulses acknowledge under four seconds
// RULE20: stop key acknowledges while fault present
// RULE21: acknowledge while running makes motor coast
// RULE22: edge select 00 rise, 01 fall, 02 clear
// RULE23: any fault inhibits output until acknowledged
// RULE24: count increments per record, kept on acknowledge
module fsv_fault_supervisor #(
  parameter integer ALARM_CYCLES = `FSV_ALARM_DELAY_MS * (`FSV_CLK_HZ / 1000),
  parameter [39:0] MAINS_CYCLES = `FSV_MAINS_DELAY_S * `FSV_CLK_HZ,
  parameter integer NUM_IN = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NUM_IN-1:0] digital_in,
  input wire supply_dip,
  input wire mains_over,
  input wire temp_over,
  input wire gate_comm_err,
  input wire comm_timeout,
  input wire undervoltage,
  input wire stop_key,
  input wire drive_running,
  input wire [15:0] out_freq,
  input wire [15:0] out_current,
  input wire [15:0] dc_link_volt,
  input wire [23:0] run_hours,
  input wire [23:0] power_hours,
  output reg output_inhibit,
  output reg motor_stop,
  output reg fault_present,
  output reg [15:0] display_code,
  output reg digital_out_one,
  output reg digital_out_two,
  output reg signalling_relay
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam integer NSYNC = NUM_IN + 9;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] s1;
  reg [NSYNC-1:0] s2;
  reg [NSYNC-1:0] s3;
  reg [NSYNC-1:0] clean;
  assign raw_in = {stop_key, undervoltage, comm_timeout, gate_comm_err, temp_over,
                   mains_over, supply_dip, 2'b00, digital_in};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= {NSYNC{1'b0}};
      s2 <= {NSYNC{1'b0}};
      s3 <= {NSYNC{1'b0}};
      clean <= {NSYNC{1'b0}};
    end
    else
    begin
      s1 <= raw_in;
      s2 <= s1;
      s3 <= s2;
      clean <= (s2 & s3) | (clean & (s2 | s3));
    end
  end
  wire k_dip = clean[NUM_IN+2];
  wire k_mains = clean[NUM_IN+3];
  wire k_temp = clean[NUM_IN+4];
  wire k_gate = clean[NUM_IN+5];
  wire k_comm = clean[NUM_IN+6];
  wire k_underv = clean[NUM_IN+7];
  wire k_stop = clean[NUM_IN+8];
  // ****************************************
  // Configuration registers
  // ****************************************
  reg [7:0] reset_edge_select;
  reg [7:0] output_one_function_select;
  reg [7:0] output_two_function_select;
  reg [7:0] relay_function_select;
  reg [7:0] history_clear_select;
  reg [7:0] in_fn [0:NUM_IN-1];
  reg [7:0] xfault_fn;
  reg [7:0] guard_fn;
  reg [7:0] therm_fn;
  wire wr = psel & penable & pwrite;
  // Input function codes for external fault, guard and thermistor
  // are held as NUM_IN-bit assignment masks in the control register.
  genvar gi;
  wire [NUM_IN-1:0] ack_sel;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1)
    begin : g_in
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          in_fn[gi] <= (gi == NUM_IN-1) ? `FSV_FN_ACK_IN : `FSV_RST_IN_FN; // [RULE18]
        else if (wr && paddr == `FSV_A_IN_FN_BASE + gi * 4)
          in_fn[gi] <= pwdata[7:0];
      end
      assign ack_sel[gi] = (in_fn[gi] == `FSV_FN_ACK_IN) & clean[gi]; // [RULE18]
    end
  endgenerate
  wire [NUM_IN-1:0] xfault_hit = xfault_fn[NUM_IN-1:0] & clean[NUM_IN-1:0];
  wire [NUM_IN-1:0] guard_hit = guard_fn[NUM_IN-1:0] & clean[NUM_IN-1:0];
  wire [NUM_IN-1:0] th_hit = therm_fn[NUM_IN-1:0] & clean[NUM_IN-1:0];
  // ****************************************
  // Fault detection and acknowledge
  // ****************************************
  reg ack_lvl_d;
  reg stop_d;
  reg dip_d;
  reg powerup;
  reg [39:0] mains_cnt;
  reg [31:0] alarm_cnt;
  reg alarm_on;
  reg [7:0] fault_count;
  reg [7:0] rec_count [0:2];
  reg [7:0] rec_code [0:2];
  reg [15:0] rec_freq [0:2];
  reg [15:0] rec_cur [0:2];
  reg [15:0] rec_volt [0:2];
  reg [23:0] rec_run [0:2];
  reg [23:0] rec_pwr [0:2];
  wire ack_lvl = |ack_sel;
  wire ack_rise = ack_lvl & ~ack_lvl_d;
  wire ack_fall = ~ack_lvl & ack_lvl_d;
  reg in_ack;
  reg ack_stops;
  always @*
  begin
    in_ack = 1'b0;
    ack_stops = 1'b1;
    case (reset_edge_select)
      `FSV_RST_RISE_STOP: in_ack = ack_rise; // [RULE22]
      `FSV_RST_FALL_STOP: in_ack = ack_fall; // [RULE22]
      `FSV_RST_RISE_ONLY:
      begin
        in_ack = ack_rise; // [RULE22]
        ack_stops = 1'b0;
      end
      default: in_ack = ack_rise;
    endcase
  end
  wire key_ack = k_stop & ~stop_d & fault_present; // [RULE20]
  wire ack = (in_ack | key_ack) & fault_present;
  wire mains_trip = k_mains & (mains_cnt >= MAINS_CYCLES - 1); // [RULE3]
  reg [7:0] new_code;
  always @*
  begin
    new_code = `FSV_CODE_NONE;
    if (k_gate)
      new_code = `FSV_CODE_GATE; // [RULE5]
    else if (|guard_hit && (powerup || (k_dip && !dip_d)))
      new_code = `FSV_CODE_GUARD; // [RULE2]
    else if (mains_trip)
      new_code = `FSV_CODE_MAINS; // [RULE3]
    else if (k_temp)
      new_code = `FSV_CODE_TEMP; // [RULE4]
    else if (|th_hit)
      new_code = `FSV_CODE_THERM; // [RULE6]
    else if (|xfault_hit)
      new_code = `FSV_CODE_EXTERNAL; // [RULE1]
    else if (k_comm)
      new_code = `FSV_CODE_COMM; // [RULE7]
  end
  wire new_fault = (new_code != `FSV_CODE_NONE) & ~fault_present;
  wire hist_clr = wr && paddr == `FSV_A_HIST_CLEAR &&
                  (pwdata[7:0] == `FSV_CLR_A || pwdata[7:0] == `FSV_CLR_B); // [RULE12]
  integer i;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_lvl_d <= 1'b0;
      stop_d <= 1'b0;
      dip_d <= 1'b0;
      powerup <= 1'b1;
      mains_cnt <= 40'h0;
      alarm_cnt <= 32'h0;
      alarm_on <= 1'b0;
      fault_present <= 1'b0;
      fault_count <= 8'h00;
      display_code <= 16'h0000;
      output_inhibit <= 1'b1;
      motor_stop <= 1'b0;
      digital_out_one <= 1'b0;
      digital_out_two <= 1'b0;
      signalling_relay <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
      begin
        rec_count[i] <= 8'h00;
        rec_code[i] <= 8'h00;
        rec_freq[i] <= 16'h0000;
        rec_cur[i] <= 16'h0000;
        rec_volt[i] <= 16'h0000;
        rec_run[i] <= 24'h000000;
        rec_pwr[i] <= 24'h000000;
      end
    end
    else
    begin
      ack_lvl_d <= ack_lvl;
      stop_d <= k_stop;
      dip_d <= k_dip;
      powerup <= 1'b0;
      if (k_mains && mains_cnt < MAINS_CYCLES - 1)
        mains_cnt <= mains_cnt + 40'h1;
      if (new_fault)
      begin
        fault_present <= 1'b1; // [RULE23]
        fault_count <= fault_count + 8'h01; // [RULE24]
        display_code <= {8'h00, new_code};
        rec_count[0] <= fault_count + 8'h01; // [RULE11]
        rec_code[0] <= new_code;
        rec_freq[0] <= out_freq;
        rec_cur[0] <= out_current;
        rec_volt[0] <= dc_link_volt;
        rec_run[0] <= run_hours;
        rec_pwr[0] <= power_hours;
        for (i = 1; i < 3; i = i + 1)
        begin
          rec_count[i] <= rec_count[i-1]; // [RULE10]
          rec_code[i] <= rec_code[i-1];
          rec_freq[i] <= rec_freq[i-1];
          rec_cur[i] <= rec_cur[i-1];
          rec_volt[i] <= rec_volt[i-1];
          rec_run[i] <= rec_run[i-1];
          rec_pwr[i] <= rec_pwr[i-1];
        end
      end
      else if (ack)
      begin
        fault_present <= 1'b0; // [RULE24]
        display_code <= 16'h0000;
      end
      if (hist_clr && !new_fault)
      begin
        for (i = 0; i < 3; i = i + 1)
        begin
          rec_count[i] <= 8'h00; // [RULE12]
          rec_code[i] <= 8'h00;
          rec_freq[i] <= 16'h0000;
          rec_cur[i] <= 16'h0000;
          rec_volt[i] <= 16'h0000;
          rec_run[i] <= 24'h000000;
          rec_pwr[i] <= 24'h000000;
        end
      end
      if (k_underv && !fault_present && !new_fault)
        display_code <= `FSV_CODE_UNDERV; // [RULE8]
      else if (!k_underv && display_code == `FSV_CODE_UNDERV)
        display_code <= 16'h0000;
      // Inhibit follows faults, gate errors and undervoltage directly
      output_inhibit <= (fault_present & ~ack) | new_fault | k_gate | k_underv; // [RULE23] [RULE5] [RULE8]
      motor_stop <= (ack & ack_stops & drive_running) |
                    (motor_stop & drive_running); // [RULE21] [RULE22]
      if (!fault_present || ack)
      begin
        alarm_cnt <= 32'h0;
        alarm_on <= 1'b0;
      end
      else if (alarm_cnt < ALARM_CYCLES - 1)
        alarm_cnt <= alarm_cnt + 32'h1;
      else
        alarm_on <= 1'b1; // [RULE17]
      digital_out_one <= alarm_on & (output_one_function_select == `FSV_FN_ALARM_OUT); // [RULE13] [RULE16]
      digital_out_two <= alarm_on & (output_two_function_select == `FSV_FN_ALARM_OUT); // [RULE13] [RULE16]
      if (relay_function_select == `FSV_FN_RELAY_ALARM)
        signalling_relay <= ~powerup & ~alarm_on; // [RULE14] [RULE15]
      else
        signalling_relay <= 1'b0;
    end
  end
  // ****************************************
  // APB slave
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_edge_select <= `FSV_RST_RISE_STOP;
      output_one_function_select <= 8'h00;
      output_two_function_select <= 8'h00;
      relay_function_select <= `FSV_FN_RELAY_ALARM;
      history_clear_select <= `FSV_HIST_CLR_IDLE;
      xfault_fn <= 8'h00;
      guard_fn <= 8'h00;
      therm_fn <= 8'h00;
    end
    else if (wr)
    begin
      case (paddr)
        `FSV_A_CTRL:
        begin
          xfault_fn <= pwdata[7:0];
          guard_fn <= pwdata[15:8];
          therm_fn <= pwdata[23:16];
        end
        `FSV_A_RESET_EDGE: reset_edge_select <= pwdata[7:0];
        `FSV_A_OUT1_FN: output_one_function_select <= pwdata[7:0];
        `FSV_A_OUT2_FN: output_two_function_select <= pwdata[7:0];
        `FSV_A_RELAY_FN: relay_function_select <= pwdata[7:0];
        `FSV_A_HIST_CLEAR: history_clear_select <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  reg [31:0] rd;
  reg rd_ok;
  reg [1:0] ri;
  reg [11:0] ro;
  always @*
  begin
    rd = 32'h0;
    rd_ok = 1'b1;
    ri = 2'd0;
    ro = 12'h000;
    if (paddr >= `FSV_A_REC_BASE && paddr < `FSV_A_REC_BASE + 3 * `FSV_REC_STRIDE)
    begin
      ro = paddr - `FSV_A_REC_BASE;
      ri = ro[6:5];
      case (ro[4:2])
        3'd0: rd = {rec_code[ri], 8'h00, 8'h00, rec_count[ri]}; // [RULE9]
        3'd1: rd = {rec_cur[ri], rec_freq[ri]};
        3'd2: rd = {16'h0000, rec_volt[ri]};
        3'd3: rd = {8'h00, rec_run[ri]};
        3'd4: rd = {8'h00, rec_pwr[ri]};
        default: rd = 32'h0;
      endcase
    end
    else
    begin
      case (paddr)
        `FSV_A_CTRL: rd = {8'h00, therm_fn, guard_fn, xfault_fn};
        `FSV_A_RESET_EDGE: rd = {24'h0, reset_edge_select};
        `FSV_A_OUT1_FN: rd = {24'h0, output_one_function_select};
        `FSV_A_OUT2_FN: rd = {24'h0, output_two_function_select};
        `FSV_A_RELAY_FN: rd = {24'h0, relay_function_select};
        `FSV_A_IN_FN_BASE: rd = {24'h0, in_fn[0]};
        `FSV_A_IN_FN_BASE + 12'h004: rd = {24'h0, in_fn[1]};
        `FSV_A_IN_FN_BASE + 12'h008: rd = {24'h0, in_fn[2]};
        `FSV_A_IN_FN_BASE + 12'h00c: rd = {24'h0, in_fn[3]};
        `FSV_A_IN_FN_BASE + 12'h010: rd = {24'h0, in_fn[4]};
        `FSV_A_HIST_CLEAR: rd = {24'h0, history_clear_select};
        `FSV_A_STATUS: rd = {13'h0, alarm_on, output_inhibit, fault_present, display_code};
        `FSV_A_COUNT: rd = {24'h0, fault_count};
        default: rd_ok = 1'b0;
      endcase
    end
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      if (psel && !penable && !pwrite)
        prdata <= rd;
    end
  end
endmodule // fsv_fault_supervisor
`default_nettype wire

// ===== fsv_field_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Field side model
// ****************
module fsv_field_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ack_go,
  input wire logic run_req,
  input wire logic motor_stop,
  output logic ack_line,
  output logic drive_running,
  output logic [15:0] out_freq,
  output logic [15:0] out_current,
  output logic [15:0] dc_link_volt,
  output logic [23:0] run_hours,
  output logic [23:0] power_hours
);
  int hold;
  int coast;
  logic stopped;
  assign out_freq = 16'h0123;
  assign out_current = 16'h0456;
  assign dc_link_volt = 16'h0789;
  assign run_hours = 24'h000abc;
  assign power_hours = 24'h000def;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ack_line <= 1'b0;
      hold <= 0;
      coast <= 0;
      stopped <= 1'b0;
      drive_running <= 1'b0;
    end
    else
    begin
      // Acknowledge is raised, then released far inside four seconds
      if (ack_go)
      begin
        ack_line <= 1'b1;
        hold <= 10;
      end
      else if (hold != 0)
      begin
        hold <= hold - 1;
        ack_line <= (hold > 1);
      end
      // Motor coasts down a few cycles after the stop request
      coast <= motor_stop ? coast + 1 : 0;
      stopped <= run_req && (stopped || coast >= 3);
      drive_running <= run_req && !stopped;
    end
endmodule // fsv_field_model
`default_nettype wire

// ===== fsv_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module fsv_properties #(
  parameter integer ALARM_CYCLES = 20,
  parameter integer NUM_IN = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire stop_key,
  input wire [NUM_IN-1:0] digital_in,
  input wire gate_comm_err,
  input wire undervoltage,
  input wire drive_running,
  input wire output_inhibit,
  input wire motor_stop,
  input wire fault_present,
  input wire digital_out_one,
  input wire signalling_relay
);
  int age;
  int quiet;
  // Fault age and cycles since stop_key or any digital input last changed
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      age <= 0;
      quiet <= 0;
    end
    else
    begin
      age <= fault_present ? age + 1 : 0;
      quiet <= ($changed(stop_key) || $changed(digital_in)) ? 0 : quiet + 1;
    end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_key_ack;
    fault_present && $rose(stop_key);
  endsequence
  sequence s_run_ack;
    s_key_ack ##0 drive_running;
  endsequence
  AST_INHIBIT: assert property (fault_present |-> output_inhibit)
    else $error("fault without inhibit");
  AST_HOLD: assert property (fault_present && quiet >= 8 |=> fault_present)
    else $error("fault cleared without acknowledge");
  AST_GATE: assert property ($rose(gate_comm_err) |-> ##[1:6] output_inhibit)
    else $error("gate error did not inhibit");
  AST_UNDERV: assert property (undervoltage [*6] |-> output_inhibit)
    else $error("undervoltage did not inhibit");
  AST_KEY_ACK: assert property (s_key_ack |-> ##[1:8] !fault_present)
    else $error("stop key did not acknowledge");
  AST_COAST: assert property (s_run_ack |-> ##[1:8] motor_stop)
    else $error("acknowledge while running gave no stop");
  AST_STOP_CAUSE: assert property ($rose(motor_stop) |-> $past(drive_running))
    else $error("stop without running drive");
  AST_ALARM_EARLY: assert property (age < ALARM_CYCLES - 1 |-> !digital_out_one)
    else $error("alarm too early");
  AST_ALARM_LATE: assert property (age >= ALARM_CYCLES + 3 |-> digital_out_one && !signalling_relay)
    else $error("alarm or relay missing");
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("no zero wait answer");
endmodule // fsv_properties
bind fsv_fault_supervisor fsv_properties #(.ALARM_CYCLES(ALARM_CYCLES), .NUM_IN(NUM_IN)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .stop_key(stop_key), .digital_in(digital_in), .gate_comm_err(gate_comm_err),
  .undervoltage(undervoltage), .drive_running(drive_running), .output_inhibit(output_inhibit),
  .motor_stop(motor_stop), .fault_present(fault_present), .digital_out_one(digital_out_one),
  .signalling_relay(signalling_relay));
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Testbench
// ****************
module tb;
  localparam integer ALARM = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cnt;
  logic [6:0] ins;
  logic supply_dip, undervoltage, stop_key, ack_go, run_req, ack_line, drive_running;
  logic [15:0] out_freq, out_current, dc_link_volt, display_code;
  logic [23:0] run_hours, power_hours;
  logic output_inhibit, motor_stop, fault_present, out_one, out_two, relay;
  logic [55:0] codes;
  int n_fail, n_checks, m;
  fsv_fault_supervisor #(.ALARM_CYCLES(ALARM), .MAINS_CYCLES(50), .NUM_IN(5)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_in({ack_line, 1'b0, ins[6], ins[3], ins[4]}), .supply_dip(supply_dip),
    .mains_over(ins[1]), .temp_over(ins[2]), .gate_comm_err(ins[0]), .comm_timeout(ins[5]),
    .undervoltage(undervoltage), .stop_key(stop_key), .drive_running(drive_running),
    .out_freq(out_freq), .out_current(out_current), .dc_link_volt(dc_link_volt),
    .run_hours(run_hours), .power_hours(power_hours), .output_inhibit(output_inhibit),
    .motor_stop(motor_stop), .fault_present(fault_present), .display_code(display_code),
    .digital_out_one(out_one), .digital_out_two(out_two), .signalling_relay(relay));
  fsv_field_model model (.pclk(pclk), .presetn(presetn), .ack_go(ack_go), .run_req(run_req),
    .motor_stop(motor_stop), .ack_line(ack_line), .drive_running(drive_running),
    .out_freq(out_freq), .out_current(out_current), .dc_link_volt(dc_link_volt),
    .run_hours(run_hours), .power_hours(power_hours));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_fp(input logic v);
    repeat (300) if (fault_present !== v) @(posedge pclk);
    chk(fault_present, v);
  endtask
  task complete_run;
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    #400000;
    n_fail++;
    complete_run;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ins} = '0;
    {supply_dip, undervoltage, stop_key, ack_go, run_req} = '0;
    codes = 56'h30152135126013;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h18);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    chk(relay, 1'b1);
    apb(1'b1, 12'h008, 32'h05);
    apb(1'b1, 12'h000, 32'h00020401);
    for (int k = 0; k < 7; k++)
    begin
      m = (k % 4 == 0) ? 0 : k % 4 - 1;
      if (k == 2)
        apb(1'b1, 12'h028, 32'h00);
      apb(1'b1, 12'h004, m);
      apb(1'b0, 12'h030, 32'h0);
      cnt = rd;
      run_req <= 1'b1;
      if (k == 6)
      begin
        ins[6] <= 1'b1;
        repeat (8) @(posedge pclk);
        supply_dip <= 1'b1;
      end
      else
        ins[k] <= 1'b1;
      wait_fp(1'b1);
      repeat (ALARM + 8) @(posedge pclk);
      chk(display_code, codes[55-8*k -: 8]);
      chk({out_one, out_two, relay}, 3'b100);
      apb(1'b0, 12'h040, 32'h0);
      chk({rd[31:24], rd[7:0]}, {codes[55-8*k -: 8], cnt[7:0] + 8'h01});
      apb(1'b0, 12'h044, 32'h0);
      chk(rd, 32'h04560123);
      apb(1'b0, 12'h048, 32'h0);
      chk(rd, 32'h00000789);
      apb(1'b0, 12'h04c, 32'h0);
      chk(rd, 32'h00000abc);
      ins <= '0;
      supply_dip <= 1'b0;
      repeat (8) @(posedge pclk);
      stop_key <= (k % 4 == 0);
      ack_go <= (k % 4 != 0);
      @(posedge pclk);
      ack_go <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(fault_present, m == 1);
      stop_key <= 1'b0;
      wait_fp(1'b0);
      repeat (6) @(posedge pclk);
      chk(drive_running, m == 2);
      apb(1'b0, 12'h030, 32'h0);
      chk(rd, cnt + 1);
      run_req <= 1'b0;
      if (k == 2)
      begin
        apb(1'b0, 12'h060, 32'h0);
        chk(rd, 32'h0);
      end
    end
    apb(1'b0, 12'h060, 32'h0);
    chk(rd[31:24], 8'h60);
    apb(1'b0, 12'h080, 32'h0);
    chk(rd[31:24], 8'h12);
    apb(1'b1, 12'h028, 32'h02);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    undervoltage <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({output_inhibit, display_code}, 17'h18888);
    complete_run;
  end
endmodule // tb
`default_nettype wire
